// ==== design/gtm_consts.vh ====
// Purpose: Offsets, field positions, reset values and codes of the timer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Included by the timer, its checker and its testbench; not by the prescaler.
`ifndef GTM_CONSTS_VH
`define GTM_CONSTS_VH

`define GTM_ADDR_CONTROL    12'h000
`define GTM_ADDR_COUNT      12'h004
`define GTM_ADDR_PERIOD     12'h008
`define GTM_ADDR_STATUS     12'h00C
`define GTM_ADDR_MASK       12'h010
`define GTM_ADDR_PRIORITY   12'h014

`define GTM_BIT_ON          15
`define GTM_BIT_SIDL        13
`define GTM_BIT_ECS_HI      9
`define GTM_BIT_ECS_LO      8
`define GTM_BIT_GATE        6
`define GTM_BIT_PS_HI       5
`define GTM_BIT_PS_LO       4
`define GTM_BIT_SYNC        2
`define GTM_BIT_CS          1
`define GTM_CONTROL_MASK    16'hA376

`define GTM_ECS_PIN         2'h0
`define GTM_ECS_LOW_POWER_RC_OSCILLATOR        2'h2

`define GTM_ST_MATCH        0
`define GTM_ST_GATE         1

`define GTM_RESET_CONTROL   16'h0000
`define GTM_RESET_COUNT     16'h0000
`define GTM_RESET_PERIOD    16'hFFFF
`define GTM_RESET_STATUS    2'h0
`define GTM_RESET_MASK      2'h0
`define GTM_RESET_PRIORITY  3'h0

`endif

// ==== design/gtm_prescaler.v ====
// Purpose: Divides a one-cycle count enable by 1, 8, 64 or 256.
// Assumes: Enable pulses are one clock wide.
// Notes:   Cleared whenever the timer is off.
`timescale 1ns/1ps

module gtm_prescaler (
  input  wire       clock,
  input  wire       reset,
  input  wire       clear,
  input  wire [1:0] select,
  input  wire       tick_in,
  output wire       tick_out
);

  reg  [7:0] divide_count;
  reg  [7:0] last_value;

  always @* begin
    case (select)
      2'h0:    last_value = 8'h00;
      2'h1:    last_value = 8'h07;
      2'h2:    last_value = 8'h3F;
      default: last_value = 8'hFF;
    endcase
  end

  assign tick_out = tick_in && (divide_count == last_value);

  always @(posedge clock) begin
    if (reset || clear) begin
      divide_count <= 8'h00;
    end else if (tick_in) begin
      if (divide_count >= last_value) begin
        divide_count <= 8'h00;
      end else begin
        divide_count <= divide_count + 8'h01;
      end
    end
  end

endmodule

// ==== design/gtm_timer.v ====
// Purpose: Sixteen-bit timer and counter with APB registers.
// Assumes: One 100 MHz clock; pins and the RC clock are asynchronous.
// Notes:   The asynchronous counting mode is emulated on the system clock.
//
// Function
// - 16-bit up counter used as interval timer or real-time clock base.
// - Counts internal clock, synchronised external clock, or async external.
// - Interrupt on period match and on gate falling edge when gated.
// - Keeps counting in idle or sleep when configured, to wake the CPU.
// - Counts only while the on bit is set.
// - Two-bit prescale field divides the selected clock.
// - Source bit, extended source field and gate bit pick the clock.
// - Sync bit chooses synchronised or asynchronous external counting.
// - Extended source value 10 selects the low-power RC oscillator.
// - Stop-in-idle bit halts the timer in idle; clear keeps it running.
// - Gate enable bit turns gated time accumulation on or off.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "gtm_consts.vh"

module gtm_timer (
  input  wire        clock,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        timer_external_clock_pin,
  input  wire        low_power_rc_oscillator,
  input  wire        cpu_idle,
  input  wire        cpu_sleep,
  output reg         irq,
  output reg  [2:0]  timer_interrupt_priority,
  output reg         period_match
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [15:0] timer_control;
  reg  [15:0] count_value;
  reg  [15:0] period_register;
  reg  [1:0]  status;
  reg  [1:0]  mask;

  wire timer_on_bit          = timer_control[`GTM_BIT_ON];
  wire stop_in_idle_bit      = timer_control[`GTM_BIT_SIDL];
  wire gate_enable_bit       = timer_control[`GTM_BIT_GATE];
  wire external_clock_sync_bit = timer_control[`GTM_BIT_SYNC];
  wire clock_source_select_bit = timer_control[`GTM_BIT_CS];
  wire [1:0] extended_clock_source_field =
    timer_control[`GTM_BIT_ECS_HI:`GTM_BIT_ECS_LO];
  wire [1:0] prescale_select_field =
    timer_control[`GTM_BIT_PS_HI:`GTM_BIT_PS_LO];

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // The second stage feeds an extra edge-history flop so that the first
  // stage is read by nothing but the second.
  reg  [1:0] pin_sync;
  reg  [1:0] rc_sync;
  reg        pin_last;
  reg        rc_last;

  always @(posedge clock) begin
    if (reset) begin
      pin_sync <= 2'h0;
      rc_sync  <= 2'h0;
      pin_last <= 1'b0;
      rc_last  <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[0], timer_external_clock_pin};
      rc_sync  <= {rc_sync[0], low_power_rc_oscillator};
      pin_last <= pin_sync[1];
      rc_last  <= rc_sync[1];
    end
  end

  // ---------------------------------------------------------------
  // Clock source selection
  // ---------------------------------------------------------------
  wire ext_level = (extended_clock_source_field == `GTM_ECS_LOW_POWER_RC_OSCILLATOR) ?
                   rc_sync[1] : pin_sync[1];
  wire ext_prev  = (extended_clock_source_field == `GTM_ECS_LOW_POWER_RC_OSCILLATOR) ?
                   rc_last : pin_last;
  wire ext_rise  = ext_level && !ext_prev;

  // ---------------------------------------------------------------
  // Power modes
  // ---------------------------------------------------------------
  // Idle halts only when the stop-in-idle bit is set. Sleep stops the
  // system clock that the internal and synchronised modes depend on, so
  // only the asynchronous external mode keeps counting there and can
  // serve as a wake-up source.
  wire idle_halt  = cpu_idle && stop_in_idle_bit;
  wire sleep_halt = cpu_sleep &&
                    (!clock_source_select_bit ||
                     external_clock_sync_bit);
  wire halted     = idle_halt || sleep_halt;

  // Both external modes count the synchronised edge here, since the whole
  // block runs on one clock; the asynchronous mode differs in that it
  // keeps running through sleep. A pin faster than half of the
  // system clock is therefore undercounted in either mode.

  // Gated accumulation counts the internal clock while the gate is high.
  wire raw_tick =
    clock_source_select_bit ? ext_rise :
    gate_enable_bit ? pin_sync[1] : 1'b1;

  wire count_enable = timer_on_bit && !halted && raw_tick;
  wire count_tick;

  gtm_prescaler u_prescaler (
    .clock    (clock),
    .reset    (reset),
    .clear    (!timer_on_bit),
    .select   (prescale_select_field),
    .tick_in  (count_enable),
    .tick_out (count_tick)
  );

  // ---------------------------------------------------------------
  // Counter and events
  // ---------------------------------------------------------------
  wire hit_period = count_tick && (count_value == period_register);
  wire gate_fall  = timer_on_bit && gate_enable_bit &&
                    !clock_source_select_bit &&
                    !pin_sync[1] && pin_last;

  // ---------------------------------------------------------------
  // Register strobes
  // ---------------------------------------------------------------
  // A write lands only at the edge that acknowledges the access phase;
  // a read is latched at the setup edge so that its data stands in the
  // one acknowledged access cycle.
  wire apb_setup    = psel && !penable;
  wire apb_write    = psel && penable && pwrite && pready;
  wire apb_read     = apb_setup && !pwrite;

  wire sel_control  = (paddr == `GTM_ADDR_CONTROL);
  wire sel_count    = (paddr == `GTM_ADDR_COUNT);
  wire sel_period   = (paddr == `GTM_ADDR_PERIOD);
  wire sel_status   = (paddr == `GTM_ADDR_STATUS);
  wire sel_mask     = (paddr == `GTM_ADDR_MASK);
  wire sel_priority = (paddr == `GTM_ADDR_PRIORITY);

  wire wr_control   = apb_write && sel_control;
  wire wr_count     = apb_write && sel_count;
  wire wr_period    = apb_write && sel_period;
  wire wr_status    = apb_write && sel_status;
  wire wr_mask      = apb_write && sel_mask;
  wire wr_priority  = apb_write && sel_priority;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // A software write to the count wins over a tick in the same cycle, so
  // the value read back is the one written.
  always @(posedge clock) begin
    if (reset) begin
      count_value <= `GTM_RESET_COUNT;
    end else if (wr_count) begin
      count_value <= pwdata[15:0];
    end else if (count_tick) begin
      if (hit_period) begin
        count_value <= 16'h0000;
      end else begin
        count_value <= count_value + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Zero wait states: pready is set at the edge ending setup so every access
  // finishes in its first access-phase cycle.
  wire mapped = sel_control || sel_count || sel_period ||
                sel_status || sel_mask || sel_priority;

  reg [31:0] next_prdata;

  always @* begin
    case (paddr)
      `GTM_ADDR_CONTROL:  next_prdata = {16'h0000, timer_control};
      `GTM_ADDR_COUNT:    next_prdata = {16'h0000, count_value};
      `GTM_ADDR_PERIOD:   next_prdata = {16'h0000, period_register};
      `GTM_ADDR_STATUS:   next_prdata = {30'h0, status};
      `GTM_ADDR_MASK:     next_prdata = {30'h0, mask};
      `GTM_ADDR_PRIORITY: next_prdata = {29'h0, timer_interrupt_priority};
      default:            next_prdata = 32'h00000000;
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (apb_read) begin
        prdata <= next_prdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // Unimplemented control bits are dropped on write so that they read
  // back as zero.
  always @(posedge clock) begin
    if (reset) begin
      timer_control <= `GTM_RESET_CONTROL;
    end else if (wr_control) begin
      timer_control <= pwdata[15:0] & `GTM_CONTROL_MASK;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      period_register <= `GTM_RESET_PERIOD;
    end else if (wr_period) begin
      period_register <= pwdata[15:0];
    end
  end

  // Mask and priority are plain storage; the mask gates the level
  // interrupt and the priority is handed on to the interrupt controller.
  always @(posedge clock) begin
    if (reset) begin
      mask <= `GTM_RESET_MASK;
    end else if (wr_mask) begin
      mask <= pwdata[1:0];
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      timer_interrupt_priority <= `GTM_RESET_PRIORITY;
    end else if (wr_priority) begin
      timer_interrupt_priority <= pwdata[2:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  // A new event in the clearing cycle wins over the write of one.
  wire [1:0] events = {gate_fall, hit_period};
  wire [1:0] clear_bits = wr_status ? pwdata[1:0] : 2'h0;
  wire       irq_level  = |(status & mask);

  always @(posedge clock) begin
    if (reset) begin
      status       <= `GTM_RESET_STATUS;
      irq          <= 1'b0;
      period_match <= 1'b0;
    end else begin
      status       <= (status & ~clear_bits) | events;
      irq          <= irq_level;
      period_match <= hit_period;
    end
  end

endmodule

// ==== verification/gtm_pin_source.sv ====
// Purpose: Drives the timer's external clock, gate or RC oscillator pin.
// Assumes: Runs from the bench clock; idle pin holds the gate level.
// Notes:   A toggling pin goes to the level input when run is low.
`timescale 1ns/1ps

module gtm_pin_source (
  input  logic       clock,
  input  logic       run,
  input  logic       level,
  input  logic [7:0] half,
  output logic       pin
);
  logic [7:0] cnt = 8'h00;
  initial pin = 1'b0;
  always @(posedge clock) begin
    if (!run) begin
      pin <= level;
      cnt <= 8'h00;
    end else if (cnt == half) begin
      pin <= ~pin;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ==== verification/gtm_timer_chk.sv ====
// Purpose: Bus and output checks on the timer ports.
// Assumes: One clock, synchronous reset.
// Notes:   Bound to every timer instance at the foot.
`timescale 1ns/1ps
`include "gtm_consts.vh"

module gtm_timer_chk (
  input logic        clock,
  input logic        reset,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        irq,
  input logic [2:0]  timer_interrupt_priority,
  input logic        period_match
);
  logic       on_q;
  logic [2:0] prio_q;
  wire        acc = psel && penable && pready;
  wire        wprio = acc && pwrite && paddr == `GTM_ADDR_PRIORITY;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  always @(posedge clock) begin
    if (reset) on_q <= 1'b0;
    else if (acc && pwrite && paddr == `GTM_ADDR_CONTROL) on_q <= pwdata[15];
    if (wprio) prio_q <= pwdata[2:0];
  end
  AST_READY_AFTER_SETUP: assert property (
    psel && !penable |=> pready) else $error("no pready after setup");
  AST_READY_ONE_CYCLE: assert property (
    pready |=> !pready) else $error("pready held too long");
  AST_READY_IN_ACCESS: assert property (
    pready |-> psel && penable) else $error("pready outside access");
  AST_ERR_UNMAPPED: assert property (
    pready && paddr > 12'h014 |-> pslverr) else $error("no error flag");
  AST_ERR_READ_ZERO: assert property (
    pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("bad error read");
  AST_UPPER_ZERO: assert property (
    pready |-> prdata[31:16] == 16'h0) else $error("upper bits set");
  AST_PRIO_COPY: assert property (
    wprio |=> ##[0:1] timer_interrupt_priority == prio_q)
    else $error("priority not copied");
  AST_OFF_NO_MATCH: assert property (
    !on_q [*4] |-> !period_match) else $error("match while off");
  cover property (period_match && irq);
  cover property (pslverr);
  cover property (wprio);
endmodule

bind gtm_timer gtm_timer_chk chk (.clock(clock), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .timer_interrupt_priority(timer_interrupt_priority),
  .period_match(period_match));

// ==== verification/tb_top.sv ====
// Purpose: Register-level tests of the sixteen-bit timer.
// Assumes: APB master tasks; pin and RC clock from partner models.
// Notes:   Counts are checked with a small window for sync latency.
`timescale 1ns/1ps
`include "gtm_consts.vh"

module tb_top;
  logic        clock, reset, psel, penable, pwrite, idle, sleep, err;
  logic        p_run, p_lvl, r_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire  [2:0]  prio;
  wire         pready, pslverr, irq, match, pin, rc;
  int          fail_count = 0, total_checks = 0, i, lo;
  logic [15:0] ctl [3] = '{16'h8006, 16'h8002, 16'h8206};

  gtm_timer dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_external_clock_pin(pin), .low_power_rc_oscillator(rc),
    .cpu_idle(idle), .cpu_sleep(sleep), .irq(irq),
    .timer_interrupt_priority(prio), .period_match(match));
  gtm_pin_source src (.clock(clock), .run(p_run), .level(p_lvl),
    .half(8'h03), .pin(pin));
  gtm_pin_source osc (.clock(clock), .run(r_run), .level(1'b0),
    .half(8'h01), .pin(rc));

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic check(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd, e);
  endtask
  task automatic run_for(input int n, input logic [15:0] c);
    xfer(1'b1, `GTM_ADDR_COUNT, 32'h0);
    xfer(1'b1, `GTM_ADDR_CONTROL, {16'h0, c});
    repeat (n) @(posedge clock);
    xfer(1'b1, `GTM_ADDR_CONTROL, 32'h0);
    xfer(1'b0, `GTM_ADDR_COUNT, 32'h0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #300us;
    fail_count++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, idle, sleep, p_run, p_lvl, r_run} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    reset = 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 6; i++) rchk(i * 4, (i == 2) ? 32'hFFFF : 32'h0);
    rchk(12'h018, 32'h0);
    check("slverr", err, 1'b1);
    xfer(1'b1, `GTM_ADDR_CONTROL, 32'hFFFF);
    rchk(`GTM_ADDR_CONTROL, 32'hA376);
    for (i = 0; i < 8; i++) begin
      xfer(1'b1, `GTM_ADDR_PRIORITY, i);
      check("priority", prio, i);
    end
    xfer(1'b1, `GTM_ADDR_PERIOD, 32'h4);
    xfer(1'b1, `GTM_ADDR_MASK, 32'h1);
    run_for(20, 16'h8000);
    check("count bound", rd <= 4, 1'b1);
    check("irq on match", irq, 1'b1);
    lo = rd;
    repeat (10) @(posedge clock);
    rchk(`GTM_ADDR_COUNT, lo);
    xfer(1'b1, `GTM_ADDR_STATUS, 32'h3);
    rchk(`GTM_ADDR_STATUS, 32'h0);
    check("irq cleared", irq, 1'b0);
    xfer(1'b1, `GTM_ADDR_PERIOD, 32'hFFFF);
    for (i = 0; i < 4; i++) begin
      run_for(1024, 16'h8000 | (i << 4));
      lo = 1027 / ((i == 3) ? 256 : (1 << (3 * i)));
      check("prescale", rd + 2 >= lo && rd <= lo + 1, 1'b1);
    end
    p_run <= 1'b1;
    r_run <= 1'b1;
    for (i = 0; i < 3; i++) begin
      sleep <= (i == 1);
      run_for(800, ctl[i]);
      lo = (i == 2) ? 200 : 100;
      check("ext count", rd + 2 >= lo && rd <= lo + 2, 1'b1);
    end
    sleep <= 1'b1;
    run_for(800, ctl[0]);
    check("sync in sleep", rd, 32'h0);
    p_run <= 1'b0;
    r_run <= 1'b0;
    sleep <= 1'b0;
    p_lvl <= 1'b1;
    xfer(1'b1, `GTM_ADDR_MASK, 32'h2);
    xfer(1'b1, `GTM_ADDR_COUNT, 32'h0);
    xfer(1'b1, `GTM_ADDR_CONTROL, 32'h8040);
    repeat (20) @(posedge clock);
    p_lvl <= 1'b0;
    repeat (10) @(posedge clock);
    rchk(`GTM_ADDR_STATUS, 32'h2);
    check("irq on gate", irq, 1'b1);
    xfer(1'b0, `GTM_ADDR_COUNT, 32'h0);
    lo = rd;
    check("gated count", lo >= 20, 1'b1);
    rchk(`GTM_ADDR_COUNT, lo);
    xfer(1'b1, `GTM_ADDR_CONTROL, 32'h0);
    idle <= 1'b1;
    run_for(50, 16'hA000);
    check("idle stop", rd, 32'h0);
    run_for(50, 16'h8000);
    check("idle run", rd >= 50, 1'b1);
    end_of_test();
  end
endmodule
